//--- verilog/lsr_pkg.sv
// Package with register map and field layout of the segment register bank
package lsr_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] LSR_OFF_IRQ_CFG  = 8'h14;
    localparam logic [7:0] LSR_OFF_COM_SEL  = 8'h24;
    localparam logic [7:0] LSR_OFF_SEG_SEL  = 8'h28;
    localparam logic [7:0] LSR_OFF_PAT_C4   = 8'h3c;
    localparam logic [7:0] LSR_OFF_PAT_C5   = 8'h40;
    localparam logic [7:0] LSR_OFF_PAT_C6   = 8'h44;
    localparam logic [7:0] LSR_OFF_PAT_C7   = 8'h48;
    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int LSR_PAT_W     = 28;
    localparam int LSR_COM_W     = 8;
    localparam int LSR_SEG_W     = 16;
    localparam int LSR_PORTC_W   = 12;
    localparam int LSR_NUM_PAT   = 4;
    localparam int LSR_BIT_EN    = 0;
    localparam int LSR_BIT_STAT  = 1;
    localparam int LSR_BIT_CLR   = 2;
    localparam int LSR_DSEL_LED  = 2;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [27:0] LSR_PAT_RST = 28'h000_0000;
    localparam logic [7:0]  LSR_COM_RST = 8'h00;
    localparam logic [15:0] LSR_SEG_RST = 16'h0000;
    localparam logic [31:0] LSR_ZERO    = 32'h0000_0000;
endpackage : lsr_pkg

//--- verilog/lsr_scan_flag.sv
// Sticky scan-complete flag with write-one clear and interrupt gating
`timescale 1ns/1ps
module lsr_scan_flag
    import lsr_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic scan_done,
    input  wire logic clear,
    input  wire logic enable,
    output logic      flag,
    output logic      irq
);
    logic flag_reg;
    logic flag_next;

    // Set wins over a clear in the same cycle
    always_comb begin
        flag_next = flag_reg;
        if (clear) begin
            flag_next = 1'b0;
        end
        if (scan_done) begin
            flag_next = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign flag = flag_reg;
    assign irq  = flag_reg & enable;
endmodule // lsr_scan_flag

//--- verilog/lsr_regs.sv
// Segment data, scan interrupt and pin selection register bank
`timescale 1ns/1ps
module lsr_regs
    import lsr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [31:0]      rdata,
    input  wire logic [2:0]  display_control,
    input  wire logic        matrix_mode,
    input  wire logic        high_current_en,
    input  wire logic        scan_done,
    output logic             led_irq,
    output logic [27:0]      led_seg_c4,
    output logic [27:0]      led_seg_c5,
    output logic [27:0]      led_seg_c6,
    output logic [27:0]      led_seg_c7,
    output logic [27:0]      lcd_seg_c4,
    output logic [27:0]      lcd_seg_c5,
    output logic [27:0]      lcd_seg_c6,
    output logic [27:0]      lcd_seg_c7,
    output logic [7:0]       porta_common_mode,
    output logic [11:0]      portc_segment_mode,
    output logic [3:0]       portd_segment_mode
);
    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [27:0] pattern_reg [LSR_NUM_PAT];
    logic [27:0] pattern_next [LSR_NUM_PAT];
    logic [7:0]  common_pin_select_reg;
    logic [7:0]  common_pin_select_next;
    logic [15:0] segment_pin_select_reg;
    logic [15:0] segment_pin_select_next;
    logic        irq_en_reg;
    logic        irq_en_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic        scan_done_clear;
    logic        scan_flag;
    logic        led_sel;
    logic        com_active;
    logic [2:0]  pat_idx;

    // Pattern offset to index; used by write and read paths
    function automatic logic [2:0] pat_index(input logic [7:0] a);
        unique case (a)
            LSR_OFF_PAT_C4: pat_index = 3'd0;
            LSR_OFF_PAT_C5: pat_index = 3'd1;
            LSR_OFF_PAT_C6: pat_index = 3'd2;
            LSR_OFF_PAT_C7: pat_index = 3'd3;
            default:        pat_index = 3'(LSR_NUM_PAT);
        endcase
    endfunction

    // A function result cannot be sliced, so the index lives on a net
    assign pat_idx = pat_index(addr);

    // ------------------------------------------------------------
    // Write path
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < LSR_NUM_PAT; i++) begin
            pattern_next[i] = pattern_reg[i];
        end
        common_pin_select_next  = common_pin_select_reg;
        segment_pin_select_next = segment_pin_select_reg;
        irq_en_next             = irq_en_reg;
        scan_done_clear         = 1'b0;
        if (wr) begin
            if (pat_idx < 3'(LSR_NUM_PAT)) begin
                pattern_next[pat_idx[1:0]] =
                    wdata[LSR_PAT_W-1:0];
            end
            unique case (addr)
                LSR_OFF_IRQ_CFG: begin
                    irq_en_next     = wdata[LSR_BIT_EN];
                    // Writing zero to the clear bit does nothing
                    scan_done_clear = wdata[LSR_BIT_CLR];
                end
                LSR_OFF_COM_SEL: begin
                    common_pin_select_next = wdata[LSR_COM_W-1:0];
                end
                LSR_OFF_SEG_SEL: begin
                    segment_pin_select_next = wdata[LSR_SEG_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < LSR_NUM_PAT; i++) begin
                pattern_reg[i] <= LSR_PAT_RST;
            end
            common_pin_select_reg  <= LSR_COM_RST;
            segment_pin_select_reg <= LSR_SEG_RST;
            irq_en_reg             <= 1'b0;
        end else begin
            for (int i = 0; i < LSR_NUM_PAT; i++) begin
                pattern_reg[i] <= pattern_next[i];
            end
            common_pin_select_reg  <= common_pin_select_next;
            segment_pin_select_reg <= segment_pin_select_next;
            irq_en_reg             <= irq_en_next;
        end
    end

    // ------------------------------------------------------------
    // Scan flag and interrupt
    // ------------------------------------------------------------
    lsr_scan_flag u_flag (
        .clk       (clk),
        .rst_n     (rst_n),
        .scan_done (scan_done),
        .clear     (scan_done_clear),
        .enable    (irq_en_reg),
        .flag      (scan_flag),
        .irq       (led_irq)
    );

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_comb begin
        rdata_next = LSR_ZERO;
        if (rd) begin
            if (pat_idx < 3'(LSR_NUM_PAT)) begin
                rdata_next[LSR_PAT_W-1:0] =
                    pattern_reg[pat_idx[1:0]];
            end
            unique case (addr)
                LSR_OFF_IRQ_CFG: begin
                    rdata_next[LSR_BIT_EN]   = irq_en_reg;
                    rdata_next[LSR_BIT_STAT] = scan_flag;
                end
                LSR_OFF_COM_SEL: begin
                    rdata_next[LSR_COM_W-1:0] = common_pin_select_reg;
                end
                LSR_OFF_SEG_SEL: begin
                    rdata_next[LSR_SEG_W-1:0] = segment_pin_select_reg;
                end
                default: begin
                end
            endcase
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= LSR_ZERO;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata = rdata_reg;

    // ------------------------------------------------------------
    // Segment routing and pin functions
    // ------------------------------------------------------------
    assign led_sel = display_control[LSR_DSEL_LED];

    // Idle path sees zeros so the unused driver stays quiet
    assign led_seg_c4 = led_sel ? pattern_reg[0] : LSR_PAT_RST;
    assign led_seg_c5 = led_sel ? pattern_reg[1] : LSR_PAT_RST;
    assign led_seg_c6 = led_sel ? pattern_reg[2] : LSR_PAT_RST;
    assign led_seg_c7 = led_sel ? pattern_reg[3] : LSR_PAT_RST;
    assign lcd_seg_c4 = led_sel ? LSR_PAT_RST : pattern_reg[0];
    assign lcd_seg_c5 = led_sel ? LSR_PAT_RST : pattern_reg[1];
    assign lcd_seg_c6 = led_sel ? LSR_PAT_RST : pattern_reg[2];
    assign lcd_seg_c7 = led_sel ? LSR_PAT_RST : pattern_reg[3];

    assign com_active = matrix_mode | high_current_en;
    assign porta_common_mode =
        com_active ? common_pin_select_reg : LSR_COM_RST;

    assign portc_segment_mode =
        segment_pin_select_reg[LSR_PORTC_W-1:0];
    assign portd_segment_mode =
        segment_pin_select_reg[LSR_SEG_W-1:LSR_PORTC_W];
endmodule // lsr_regs

//--- sim/lsr_regs_properties.sv
// Port checker for the segment register bank
`timescale 1ns/1ps
module lsr_regs_checker
    import lsr_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    input wire logic [2:0]  display_control,
    input wire logic        matrix_mode,
    input wire logic        high_current_en,
    input wire logic        scan_done,
    input wire logic        led_irq,
    input wire logic [27:0] led_seg_c5,
    input wire logic [27:0] lcd_seg_c5,
    input wire logic [7:0]  porta_common_mode
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Helpers keep $past on plain signals
    logic [27:0] pat_wd;
    logic        en_wr;
    logic        clr_wr;
    assign pat_wd = wdata[27:0];
    assign en_wr  = wr && addr == LSR_OFF_IRQ_CFG && wdata[LSR_BIT_EN];
    assign clr_wr = wr && addr == LSR_OFF_IRQ_CFG && wdata[LSR_BIT_CLR];
    // A clear between event and read would rightly hide the flag
    sequence s_scan_read;
        scan_done ##1 !clr_wr ##1 (rd && addr == LSR_OFF_IRQ_CFG);
    endsequence
    sequence s_pat_led;
        (wr && addr == LSR_OFF_PAT_C5) ##1 display_control[LSR_DSEL_LED];
    endsequence
    AST_PAT_RSV: assert property (rd && addr == LSR_OFF_PAT_C5 |=>
        rdata[31:28] == 4'h0) else $error("pattern reserved bits set");
    AST_PAT_LED: assert property (s_pat_led |->
        led_seg_c5 == $past(pat_wd)) else $error("led pattern wrong");
    AST_LCD_OFF: assert property (display_control[LSR_DSEL_LED] |->
        lcd_seg_c5 == 28'h000_0000) else $error("lcd bus not idle");
    AST_SCAN: assert property (s_scan_read |=> rdata[LSR_BIT_STAT])
        else $error("scan flag not read back");
    AST_CLR: assert property (wr && addr == LSR_OFF_IRQ_CFG &&
        wdata[LSR_BIT_CLR] && !scan_done |=> !led_irq)
        else $error("irq after clear");
    AST_HOLD: assert property (led_irq &&
        !(wr && addr == LSR_OFF_IRQ_CFG) |=> led_irq)
        else $error("irq dropped on its own");
    AST_RISE: assert property ($rose(led_irq) |->
        $past(scan_done) || $past(en_wr)) else $error("irq without cause");
    AST_COM_GATE: assert property (!(matrix_mode || high_current_en)
        |-> porta_common_mode == 8'h00) else $error("common mode ungated");
endmodule // lsr_regs_checker

bind lsr_regs lsr_regs_checker i_chk (.clk, .rst_n, .addr, .wdata, .wr,
    .rd, .rdata, .display_control, .matrix_mode, .high_current_en,
    .scan_done, .led_irq, .led_seg_c5, .lcd_seg_c5, .porta_common_mode);

//--- sim/led_lcd_segment_regs_tb_top.sv
// Self-checking bench for the segment register bank
`timescale 1ns/1ps
module led_lcd_segment_regs_tb_top
    import lsr_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [2:0]  display_control = 3'h4;
    logic        matrix_mode = 1'b0;
    logic        high_current_en = 1'b0;
    logic        scan_done = 1'b0;
    logic [31:0] rdata;
    logic        led_irq;
    logic [27:0] led_seg [4];
    logic [27:0] lcd_seg [4];
    logic [7:0]  porta_common_mode;
    logic [11:0] portc_segment_mode;
    logic [3:0]  portd_segment_mode;
    int          n_mismatch = 0;
    int          checked = 0;
    logic [7:0]  offs [7] = '{8'h14, 8'h24, 8'h28, 8'h3c, 8'h40, 8'h44, 8'h48};
    logic [31:0] msk [7] = '{32'h0000_0001, 32'h0000_00ff, 32'h0000_ffff,
        32'h0fff_ffff, 32'h0fff_ffff, 32'h0fff_ffff, 32'h0fff_ffff};

    lsr_regs i_dut (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
        .display_control, .matrix_mode, .high_current_en, .scan_done,
        .led_irq, .led_seg_c4(led_seg[0]), .led_seg_c5(led_seg[1]),
        .led_seg_c6(led_seg[2]), .led_seg_c7(led_seg[3]),
        .lcd_seg_c4(lcd_seg[0]), .lcd_seg_c5(lcd_seg[1]),
        .lcd_seg_c6(lcd_seg[2]), .lcd_seg_c7(lcd_seg[3]),
        .porta_common_mode, .portc_segment_mode, .portd_segment_mode);

    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk($sformatf("rdata at %h", a), e, rdata);
    endtask

    task automatic step;
        @(posedge clk);
        #1;
    endtask

    task automatic report_and_stop;
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 7; i++) rd_chk(offs[i], 32'h0000_0000);
        for (int i = 0; i < 7; i++) begin
            wr_reg(offs[i], 32'hffff_ffff);
            rd_chk(offs[i], msk[i]);
        end
        // Unmapped place must swallow writes
        wr_reg(8'h00, 32'hffff_ffff);
        rd_chk(8'h00, 32'h0000_0000);
        chk("porta", 32'h0000_0000, {24'h0, porta_common_mode});
        @(posedge clk);
        matrix_mode <= 1'b1;
        step();
        chk("porta", 32'h0000_00ff, {24'h0, porta_common_mode});
        @(posedge clk);
        matrix_mode <= 1'b0;
        high_current_en <= 1'b1;
        wr_reg(LSR_OFF_COM_SEL, 32'h0000_005a);
        chk("porta", 32'h0000_005a, {24'h0, porta_common_mode});
        wr_reg(LSR_OFF_SEG_SEL, 32'h0000_1234);
        chk("segsel", 32'h0000_1234,
            {16'h0, portd_segment_mode, portc_segment_mode});
        for (int i = 0; i < 4; i++) wr_reg(offs[3+i], 32'hf123_4560 + i);
        // Bits 1:0 set on the LCD pass: only bit 2 may steer
        for (int k = 1; k >= 0; k--) begin
            @(posedge clk);
            display_control <= k ? 3'h4 : 3'h3;
            step();
            for (int i = 0; i < 4; i++) begin
                chk("led_seg", k ? 32'h0123_4560 + i : 0, led_seg[i]);
                chk("lcd_seg", k ? 0 : 32'h0123_4560 + i, lcd_seg[i]);
            end
        end
        @(posedge clk);
        scan_done <= 1'b1;
        @(posedge clk);
        scan_done <= 1'b0;
        #1;
        chk("led_irq", 32'h1, led_irq);
        rd_chk(LSR_OFF_IRQ_CFG, 32'h0000_0003);
        wr_reg(LSR_OFF_IRQ_CFG, 32'h0000_0001);
        rd_chk(LSR_OFF_IRQ_CFG, 32'h0000_0003);
        wr_reg(LSR_OFF_IRQ_CFG, 32'h0000_0000);
        chk("led_irq", 32'h0, led_irq);
        rd_chk(LSR_OFF_IRQ_CFG, 32'h0000_0002);
        wr_reg(LSR_OFF_IRQ_CFG, 32'h0000_0001);
        chk("led_irq", 32'h1, led_irq);
        wr_reg(LSR_OFF_IRQ_CFG, 32'h0000_0005);
        chk("led_irq", 32'h0, led_irq);
        rd_chk(LSR_OFF_IRQ_CFG, 32'h0000_0001);
        // Event and clear in one cycle: the set wins
        @(posedge clk);
        scan_done <= 1'b1;
        wr <= 1'b1;
        addr <= LSR_OFF_IRQ_CFG;
        wdata <= 32'h0000_0005;
        @(posedge clk);
        scan_done <= 1'b0;
        wr <= 1'b0;
        rd_chk(LSR_OFF_IRQ_CFG, 32'h0000_0003);
        // Mid-run reset must bring every register back to zero
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 7; i++) rd_chk(offs[i], 32'h0000_0000);
        chk("led_irq", 32'h0, led_irq);
        chk("porta", 32'h0000_0000, {24'h0, porta_common_mode});
        chk("lcd_seg", 32'h0, lcd_seg[1]);
        report_and_stop();
    end

    // Whole run is some hundred and fifteen cycles
    initial begin
        repeat (2000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end
endmodule // led_lcd_segment_regs_tb_top
